// ### rtc_tamper_top.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`include "rtc_defines.svh"
module rtc_tamper_top
    import rtc_pkg::*;
#(
    parameter int SAMPLE_LOG2 = `SAMPLE_LOG2
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic wp_unlocked,
    input wire logic timestamp_enable,
    input wire logic timestamp_event,
    input wire logic [2:0] week_day_units,
    input wire logic month_tens,
    input wire logic [3:0] month_units,
    input wire logic [1:0] date_tens,
    input wire logic [3:0] date_units,
    input wire logic [15:0] prescaler_count,
    input wire logic lse_enabled,
    input wire logic rtc_af_enabled,
    input wire logic alarm_on_pin13,
    input wire logic alarm_level,
    input wire logic tamper_input1,
    input wire logic tamper_input2,
    output logic [1:0] tamper_pullup_en,
    output logic pin13_out,
    output logic pin13_oe,
    output logic pin14_out,
    output logic pin14_oe,
    output logic pin15_out,
    output logic pin15_oe,
    output logic timestamp_flag,
    output logic tamper_irq,
    output logic cal_mask_pulse,
    output logic cal_insert_pulse
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [8:0] calibration_minus_of(input logic [31:0] cal);
        logic [8:0] v;
        v = cal[8:0];
        if (cal[`CAL_W8])
            v[1:0] = 2'b00;
        else if (cal[`CAL_W16])
            v[0] = 1'b0;
        return v;
    endfunction

    function automatic logic [31:0] cal_view(input logic [31:0] cal);
        return {cal[31:9], calibration_minus_of(cal)};
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [31:0] ts_date_r;
    logic [31:0] ts_sub_r;
    logic [31:0] cal_r;
    logic [31:0] tamp_r;
    logic [2:0] status_r;
    logic [7:0] addr_r;
    logic wr_r;
    logic [31:0] rd_nxt;
    logic take;
    logic wr_cal;
    logic wr_tamp;
    logic wr_stat;
    logic clr_tsf;
    logic [SAMPLE_LOG2-1:0] scnt_r;
    logic [SAMPLE_LOG2-1:0] smask;
    logic [SAMPLE_LOG2-1:0] remain;
    logic sample_tick;
    logic [3:0] prch_cycles;
    logic ev1;
    logic ev2;
    logic tamper_ev;
    logic ts_ev;
    logic [1:0] filt;
    logic [2:0] freq;
    logic pull_want;

    assign filt = tamp_r[12:11];
    assign freq = tamp_r[10:8];

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    assign take = hsel && htrans[1] && hready;
    assign wr_cal = wr_r && (addr_r == `OFS_CAL) && wp_unlocked;
    assign wr_tamp = wr_r && (addr_r == `OFS_TAMPER);
    assign wr_stat = wr_r && (addr_r == `OFS_STATUS);
    assign clr_tsf = wr_stat && hwdata[`ST_TSF];

    always_comb
    begin
        case (haddr)
            `OFS_TS_DATE: rd_nxt = ts_date_r;
            `OFS_TS_SUB: rd_nxt = ts_sub_r;
            `OFS_CAL: rd_nxt = cal_view(cal_r);
            `OFS_TAMPER: rd_nxt = tamp_r;
            `OFS_STATUS: rd_nxt = {29'h0, status_r};
            default: rd_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_r <= 8'h00;
            wr_r <= 1'b0;
            hrdata <= `RESET_WORD;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_r <= take && hwrite;
            if (take)
                addr_r <= haddr;
            if (take && !hwrite)
                hrdata <= rd_nxt;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cal_r <= `RESET_WORD;
        else if (wr_cal)
            cal_r <= hwdata & `CAL_WMASK;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tamp_r <= `RESET_WORD;
        else if (wr_tamp)
            tamp_r <= hwdata & `TP_WMASK;
    end

    // ----------------------------------------
    // Sample clock and precharge
    // ----------------------------------------
    assign smask = SAMPLE_LOG2'((1 << (SAMPLE_LOG2 - int'(freq))) - 1);
    assign remain = smask - (scnt_r & smask);
    assign sample_tick = (remain == '0);
    assign prch_cycles = 4'h1 << tamp_r[14:13];
    assign pull_want = (filt != 2'h0) && !tamp_r[`TP_PUDIS];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            scnt_r <= '0;
        else
            scnt_r <= scnt_r + 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tamper_pullup_en <= 2'b00;
        else if (pull_want && remain != '0 && remain <= SAMPLE_LOG2'(prch_cycles))
            tamper_pullup_en <= {tamp_r[3], tamp_r[0]};
        else
            tamper_pullup_en <= 2'b00;
    end

    // ----------------------------------------
    // Tamper detectors
    // ----------------------------------------
    tamper_channel u_ch1
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(tamp_r[0]),
        .trig_level(tamp_r[1]),
        .filter(filt),
        .sample_tick(sample_tick),
        .pin(tamper_input1),
        .event_pulse(ev1)
    );

    tamper_channel u_ch2
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(tamp_r[3]),
        .trig_level(tamp_r[4]),
        .filter(filt),
        .sample_tick(sample_tick),
        .pin(tamper_input2),
        .event_pulse(ev2)
    );

    assign tamper_ev = ev1 || ev2;
    assign ts_ev = (timestamp_event && timestamp_enable) || (tamper_ev && tamp_r[7]);

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status_r <= 3'b000;
        else
        begin
            if (ts_ev)
                status_r[`ST_TSF] <= 1'b1;
            else if (clr_tsf)
                status_r[`ST_TSF] <= 1'b0;
            if (ev1)
                status_r[`ST_T1F] <= 1'b1;
            else if (wr_stat && hwdata[`ST_T1F])
                status_r[`ST_T1F] <= 1'b0;
            if (ev2)
                status_r[`ST_T2F] <= 1'b1;
            else if (wr_stat && hwdata[`ST_T2F])
                status_r[`ST_T2F] <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timestamp_flag <= 1'b0;
            tamper_irq <= 1'b0;
        end
        else
        begin
            timestamp_flag <= status_r[`ST_TSF];
            tamper_irq <= tamp_r[2] && (status_r[`ST_T1F] || status_r[`ST_T2F]);
        end
    end

    // ----------------------------------------
    // Timestamp capture
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ts_date_r <= `RESET_WORD;
            ts_sub_r <= `RESET_WORD;
        end
        else if (ts_ev)
        begin
            ts_date_r <= {16'h0, week_day_units, month_tens, month_units,
                          2'b00, date_tens, date_units};
            ts_sub_r <= {16'h0, prescaler_count};
        end
        else if (clr_tsf)
        begin
            ts_date_r <= `RESET_WORD;
            ts_sub_r <= `RESET_WORD;
        end
    end

    // ----------------------------------------
    // Smooth calibration
    // ----------------------------------------
    smooth_cal u_cal
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .cal_plus(cal_r[`CAL_PLUS]),
        .w8(cal_r[`CAL_W8]),
        .w16(cal_r[`CAL_W16]),
        .calibration_minus_eff(calibration_minus_of(cal_r)),
        .mask_pulse(cal_mask_pulse),
        .insert_pulse(cal_insert_pulse)
    );

    // ----------------------------------------
    // Forced pins
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin13_out <= 1'b0;
            pin13_oe <= 1'b0;
            pin14_out <= 1'b0;
            pin14_oe <= 1'b0;
            pin15_out <= 1'b0;
            pin15_oe <= 1'b0;
        end
        else
        begin
            pin15_oe <= tamp_r[`TP_P15_FORCE] && !lse_enabled;
            pin15_out <= tamp_r[`TP_P15_FORCE] && !lse_enabled && tamp_r[`TP_P15_VAL];
            pin14_oe <= tamp_r[`TP_P14_FORCE] && !lse_enabled;
            pin14_out <= tamp_r[`TP_P14_FORCE] && !lse_enabled && tamp_r[`TP_P14_VAL];
            if (alarm_on_pin13)
            begin
                pin13_oe <= tamp_r[`TP_P13_VAL] || !alarm_level;
                pin13_out <= tamp_r[`TP_P13_VAL] && alarm_level;
            end
            else if (tamp_r[`TP_P13_FORCE] && !rtc_af_enabled)
            begin
                pin13_oe <= 1'b1;
                pin13_out <= tamp_r[`TP_P13_VAL];
            end
            else
            begin
                pin13_oe <= 1'b0;
                pin13_out <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_ts_capture;
        ##1 status_r[`ST_TSF] ##1 timestamp_flag;
    endsequence

    sequence s_ts_clear;
        clr_tsf && !ts_ev ##1 ts_date_r == 32'h0 && ts_sub_r == 32'h0;
    endsequence

    a_ts_sub_copy: assert property (ts_ev |=> ts_sub_r[15:0] == $past(prescaler_count))
        else $error("sub-second not captured");
    a_ts_flag_rise: assert property (ts_ev |-> s_ts_capture)
        else $error("timestamp flag not raised");
    a_ts_cleared: assert property ((clr_tsf && !ts_ev) |-> s_ts_clear)
        else $error("timestamp not cleared");
    a_cal_locked: assert property ((wr_r && addr_r == `OFS_CAL && !wp_unlocked) |=> $stable(cal_r))
        else $error("calibration written while locked");
    a_calibration_minus_w8_read: assert property ((take && !hwrite && haddr == `OFS_CAL && cal_r[`CAL_W8]) |=> hrdata[1:0] == 2'b00)
        else $error("window bits not forced");
    a_pin15_drive: assert property ((tamp_r[`TP_P15_FORCE] && !lse_enabled) |=> pin15_oe && pin15_out == $past(tamp_r[`TP_P15_VAL]))
        else $error("pin 15 not forced");
    a_pin13_opendrain: assert property ((alarm_on_pin13 && !tamp_r[`TP_P13_VAL]) |=> !pin13_out && pin13_oe == !$past(alarm_level))
        else $error("pin 13 not open-drain");
    a_irq_gated: assert property (!tamp_r[2] |=> !tamper_irq)
        else $error("interrupt not gated");
    a_flag_held: assert property ((status_r[`ST_T1F] && !(wr_stat && hwdata[`ST_T1F])) |=> status_r[`ST_T1F])
        else $error("tamper flag lost");
    a_no_pullup_edge: assert property ((filt == 2'h0) |=> tamper_pullup_en == 2'b00)
        else $error("pull-up in edge mode");
    a_disabled_quiet: assert property (!tamp_r[0] && !$past(tamp_r[0]) |-> ##1 !ev1)
        else $error("disabled input raised event");

endmodule

// ### rtc_defines.svh
// How it works
// - Captured date and sub-second valid only while timestamp flag set; cleared with it.
// - Date capture: week day 15:13, month tens 12, month units 11:8, date 5:0.
// - Timestamp event copies the 16-bit prescaler count into the sub-second field.
// - Calibration register takes writes only while write protection is unlocked.
// - Calibration-plus inserts one pulse every 2048 pulses.
// - Calibration-minus masks that many pulses out of every 1048576.
// - Eight-second window forces calibration-minus bits 1:0 to zero.
// - Sixteen-second window forces calibration-minus bit 0 to zero.
// - Pins 15 and 14 forced push-pull from value bit when oscillator off.
// - Pin 13 forced push-pull from value bit when clock alternate functions off.
// - With alarm on pin 13, value bit picks open-drain or push-pull.
// - Pull-up precharges tamper inputs before each sample unless disabled.
// - Precharge code 0..3 gives 1, 2, 4 or 8 cycles.
// - Filter codes 1..3 need 2, 4 or 8 consecutive active samples.
// - Filter code 0 detects on edge with no pull-up.
// - Sampling divisor is 32768 shifted right by the rate code.
// - Timestamp-on-tamper saves a timestamp on each tamper event.
// - Filtered mode trigger bit: 0 low level, 1 high level.
// - Edge mode trigger bit: 0 rising edge, 1 falling edge.
// - Each input watched only while its own detect enable is set.
// - Tamper interrupt enable gates the interrupt request.
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_TS_DATE 8'h34
`define OFS_TS_SUB 8'h38
`define OFS_CAL 8'h3c
`define OFS_TAMPER 8'h40
`define OFS_STATUS 8'h4c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CAL_PLUS 15
`define CAL_W8 14
`define CAL_W16 13
`define CAL_WMASK 32'h0000e1ff
`define TP_P15_FORCE 23
`define TP_P15_VAL 22
`define TP_P14_FORCE 21
`define TP_P14_VAL 20
`define TP_P13_FORCE 19
`define TP_P13_VAL 18
`define TP_PUDIS 15
`define TP_WMASK 32'h00fcff9f
`define ST_TSF 0
`define ST_T1F 1
`define ST_T2F 2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RESET_WORD 32'h00000000
`define SAMPLE_LOG2 15
`define CAL_SLOT_LOG2 11
`define CAL_WIN_LOG2 20

`endif

// ### rtc_pkg.sv
package rtc_pkg;

    typedef enum logic [2:0]
    {
        CH_OFF = 3'b001,
        CH_WATCH = 3'b010,
        CH_HIT = 3'b100
    } ch_state_type;

endpackage

// ### tamper_channel.sv
`timescale 1ns/100ps
`include "rtc_defines.svh"
module tamper_channel
    import rtc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic trig_level,
    input wire logic [1:0] filter,
    input wire logic sample_tick,
    input wire logic pin,
    output logic event_pulse
);

    ch_state_type state_r;
    logic prev_r;
    logic [3:0] run_r;
    logic active;
    logic edge_hit;
    logic [3:0] need;

    assign active = (pin == trig_level);
    assign edge_hit = trig_level ? (prev_r & ~pin) : (~prev_r & pin);
    assign need = 4'h1 << filter;

    // ----------------------------------------
    // Detection state
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r <= CH_OFF;
            prev_r <= 1'b0;
            run_r <= 4'h0;
            event_pulse <= 1'b0;
        end
        else
        begin
            prev_r <= pin;
            event_pulse <= 1'b0;
            case (state_r)
                CH_OFF:
                begin
                    run_r <= 4'h0;
                    if (enable)
                        state_r <= CH_WATCH;
                end
                CH_WATCH:
                begin
                    if (!enable)
                        state_r <= CH_OFF;
                    else if (filter == 2'h0)
                    begin
                        if (edge_hit)
                            event_pulse <= 1'b1;
                    end
                    else if (sample_tick)
                    begin
                        if (!active)
                            run_r <= 4'h0;
                        else if (run_r + 4'h1 >= need)
                        begin
                            event_pulse <= 1'b1;
                            state_r <= CH_HIT;
                        end
                        else
                            run_r <= run_r + 4'h1;
                    end
                end
                CH_HIT:
                begin
                    run_r <= 4'h0;
                    if (!enable)
                        state_r <= CH_OFF;
                    else if (sample_tick && !active)
                        state_r <= CH_WATCH;
                end
                default:
                    state_r <= CH_OFF;
            endcase
        end
    end

    a_edge_event: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == CH_WATCH && enable && filter == 2'h0 && edge_hit) |=> event_pulse)
        else $error("edge not detected");

endmodule

// ### smooth_cal.sv
`timescale 1ns/100ps
`include "rtc_defines.svh"
module smooth_cal
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cal_plus,
    input wire logic w8,
    input wire logic w16,
    input wire logic [8:0] calibration_minus_eff,
    output logic mask_pulse,
    output logic insert_pulse
);

    logic [`CAL_WIN_LOG2-1:0] cnt_r;
    logic [8:0] slot;
    logic slot_start;

    assign slot_start = (cnt_r[`CAL_SLOT_LOG2-1:0] == '0);
    assign slot = w8 ? {cnt_r[17:11], 2'b00} :
                  w16 ? {cnt_r[18:11], 1'b0} : cnt_r[19:11];

    // ----------------------------------------
    // Window counter and pulse decisions
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_r <= '0;
            mask_pulse <= 1'b0;
            insert_pulse <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
            mask_pulse <= slot_start && (slot < calibration_minus_eff);
            insert_pulse <= cal_plus && slot_start;
        end
    end

    a_cal_plus: assert property (@(posedge hclk) disable iff (!hresetn)
        (cal_plus && slot_start) |=> insert_pulse)
        else $error("calibration pulse not inserted");

endmodule

// ### tamper_switch.sv
`timescale 1ns/100ps
module tamper_switch
(
    input wire logic hclk,
    input wire logic pullup_en,
    input wire logic closed,
    input wire logic level,
    output logic pin
);
    logic float_r = 1'b0;
    // ----------------------------------------
    // Open contact floats unless pulled up
    // ----------------------------------------
    always @(posedge hclk)
    begin
        float_r <= !float_r;
    end
    assign pin = closed ? level : (pullup_en ? 1'b1 : float_r);
endmodule

// ### testbench.sv
`timescale 1ns/100ps
`include "rtc_defines.svh"
module testbench;
    import rtc_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hwdata = 32'h0, hrdata, rd, m_cal = 32'h0, m_tp = 32'h0;
    logic hreadyout, hresp, wp_unlocked = 1'b0, ts_en = 1'b0, ts_ev = 1'b0;
    logic [15:0] date_w = 16'h0, presc = 16'h0;
    logic low_speed_oscillator = 1'b0, af = 1'b0, alarm = 1'b0, alarm_lvl = 1'b0;
    logic [1:0] closed = 2'b11, level = 2'b00, pull;
    logic t1, t2, p13o, p13e, p14o, p14e, p15o, p15e, ts_flag, irq, mask_p, ins_p;
    int n_mismatch = 0, n_checks = 0, run = 0, last_run = 0, gap = 0, last_gap = 0;
    rtc_tamper_top #(.SAMPLE_LOG2(8)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .wp_unlocked(wp_unlocked), .timestamp_enable(ts_en), .timestamp_event(ts_ev),
        .week_day_units(date_w[15:13]), .month_tens(date_w[12]),
        .month_units(date_w[11:8]), .date_tens(date_w[5:4]), .date_units(date_w[3:0]),
        .prescaler_count(presc), .lse_enabled(low_speed_oscillator), .rtc_af_enabled(af),
        .alarm_on_pin13(alarm), .alarm_level(alarm_lvl), .tamper_input1(t1),
        .tamper_input2(t2), .tamper_pullup_en(pull), .pin13_out(p13o), .pin13_oe(p13e),
        .pin14_out(p14o), .pin14_oe(p14e), .pin15_out(p15o), .pin15_oe(p15e),
        .timestamp_flag(ts_flag), .tamper_irq(irq), .cal_mask_pulse(mask_p),
        .cal_insert_pulse(ins_p));
    tamper_switch i_sw1 (.hclk(hclk), .pullup_en(pull[0]), .closed(closed[0]),
        .level(level[0]), .pin(t1));
    tamper_switch i_sw2 (.hclk(hclk), .pullup_en(pull[1]), .closed(closed[1]),
        .level(level[1]), .pin(t2));
    // ----------------------------------------
    // Clock, pull-up width and spacing monitor
    // ----------------------------------------
    always #10 hclk = ~hclk;
    always @(posedge hclk)
    begin
        gap++;
        if (pull[0] === 1'b1)
        begin
            if (run == 0)
            begin
                last_gap = gap;
                gap = 0;
            end
            run++;
        end
        else if (run != 0)
        begin
            last_run = run;
            run = 0;
        end
    end
    // ----------------------------------------
    // Bus master, model and checks
    // ----------------------------------------
    task automatic wait_ready();
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        if (a == `OFS_CAL && wp_unlocked)
            m_cal = d & `CAL_WMASK;
        if (a == `OFS_TAMPER)
            m_tp = d & `TP_WMASK;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
        check(hresp, 32'h0);
    endtask
    function automatic logic [31:0] cal_view();
        return m_cal & ~(m_cal[14] ? 32'h3 : {31'h0, m_cal[13]});
    endfunction
    function automatic logic [31:0] pins_exp();
        logic e15, e14, e13, o13;
        e15 = m_tp[23] & !low_speed_oscillator;
        e14 = m_tp[21] & !low_speed_oscillator;
        e13 = m_tp[19] & !af;
        o13 = m_tp[18];
        if (alarm)
        begin
            e13 = m_tp[18] | !alarm_lvl;
            o13 = m_tp[18] & alarm_lvl;
        end
        return {26'h0, e15, e15 & m_tp[22], e14, e14 & m_tp[20], e13, e13 & o13};
    endfunction
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #1000000;
        n_mismatch++;
        summarize();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] v;
        int c, m, per, p, r;
        void'($urandom(52996));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 5; i++)
            rdchk(8'h34 + 8'(i * 4) - (i == 4 ? 8'h24 : 8'h0), 32'h0);
        wr(`OFS_TS_DATE, 32'hffffffff);
        rdchk(`OFS_TS_DATE, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            v = $urandom;
            if (v[14])
                v[13] = 1'b0;
            wp_unlocked <= i[0];
            wr(`OFS_CAL, v);
            rdchk(`OFS_CAL, cal_view());
        end
        wr(`OFS_CAL, 32'h8000);
        c = 0;
        m = 0;
        repeat (8192)
        begin
            @(posedge hclk);
            c += int'(ins_p === 1'b1);
            m += int'(mask_p === 1'b1);
        end
        check(c, 4);
        check(m, 0);
        wr(`OFS_CAL, 32'h0);
        for (int i = 0; i < 12; i++)
        begin
            v = $urandom;
            low_speed_oscillator <= v[0];
            alarm <= v[1];
            af <= v[1] | v[2];
            alarm_lvl <= v[3];
            wr(`OFS_TAMPER, v & 32'h00fc0000);
            repeat (2) @(posedge hclk);
            check({p15e, p15e & p15o, p14e, p14e & p14o, p13e, p13e & p13o}, pins_exp());
            rdchk(`OFS_TAMPER, m_tp);
        end
        for (int i = 0; i < 2; i++)
        begin
            date_w <= 16'($urandom);
            presc <= 16'($urandom);
            ts_en <= i[0];
            ts_ev <= 1'b1;
            @(posedge hclk);
            ts_ev <= 1'b0;
            repeat (3) @(posedge hclk);
            check(ts_flag, {31'h0, i[0]});
            rdchk(`OFS_TS_DATE, i[0] ? {16'h0, date_w[15:8], 2'b00, date_w[5:0]} : 32'h0);
            rdchk(`OFS_TS_SUB, i[0] ? {16'h0, presc} : 32'h0);
        end
        ts_en <= 1'b0;
        wr(`OFS_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        check(ts_flag, 32'h0);
        rdchk(`OFS_TS_DATE, 32'h0);
        rdchk(`OFS_TS_SUB, 32'h0);
        for (int t = 0; t < 2; t++)
        begin
            last_run = 0;
            wr(`OFS_TAMPER, {29'h10, t[0], t[0], 1'b0});
            level[0] <= !t[0];
            wr(`OFS_TAMPER, {29'h10, t[0], t[0], 1'b1});
            level[0] <= t[0];
            level[1] <= !level[1];
            repeat (6) @(posedge hclk);
            rdchk(`OFS_STATUS, 32'h0);
            level[0] <= !t[0];
            repeat (6) @(posedge hclk);
            rdchk(`OFS_STATUS, 32'h3);
            check(irq, {31'h0, t[0]});
            check(last_run, 0);
            wr(`OFS_STATUS, 32'h7);
            rdchk(`OFS_STATUS, 32'h0);
        end
        for (int f = 1; f < 4; f++)
        begin
            p = 3 + $urandom_range(1);
            r = $urandom_range(3);
            per = 1 << (8 - p);
            wr(`OFS_TAMPER, {17'h0, 2'(r), 2'(f), 3'(p), 8'h05});
            closed[0] <= 1'b0;
            repeat (80) @(posedge hclk);
            check(last_run, 1 << r);
            check(last_gap, per);
            closed[0] <= 1'b1;
            level[0] <= 1'b0;
            c = 0;
            while (irq !== 1'b1 && c < 400)
            begin
                @(posedge hclk);
                c++;
            end
            check(c >= ((1 << f) - 1) * per && c <= (1 << f) * per + 6, 1);
            wr(`OFS_STATUS, 32'h7);
        end
        level <= 2'b10;
        closed <= 2'b11;
        wr(`OFS_TAMPER, {16'h0, 1'b1, 2'b00, 2'b01, 3'b111, 8'h1c});
        repeat (2) @(posedge hclk);
        last_run = 0;
        repeat (40) @(posedge hclk);
        check(last_run, 0);
        rdchk(`OFS_STATUS, 32'h4);
        summarize();
    end
endmodule
